// ### pkg/psu_cmd_pkg.sv
package psu_cmd_pkg;
  // link characters
  localparam logic [7:0] CH_TERM = 8'h0d;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_STATUS = 8'h73;
  localparam logic [7:0] CH_ENABLE = 8'h65;
  localparam logic [7:0] CH_RANGE_CAP = 8'h72;
  localparam logic [7:0] CH_WIDE = 8'h70;
  localparam logic [7:0] CH_VOLT = 8'h4f;
  // buffer sizes and reply lengths
  localparam int RX_DEPTH = 4;
  localparam int TX_DEPTH = 9;
  localparam logic [3:0] LEN_BOOL = 4'h4;
  localparam logic [3:0] LEN_STATUS = 4'h9;
  localparam logic [3:0] LEN_VOLT = 4'h8;
  localparam int STATUS_DIGITS = 6;
  localparam int VOLT_DIGITS = 5;
  localparam int VOLT_W = 20;
  // status word layout
  localparam int ST_W = 24;
  localparam int SB_LIM_CTRL = 0;
  localparam int SB_RED = 1;
  localparam int SB_EN_CTRL0 = 4;
  localparam int SB_WIDE_CTRL0 = 6;
  localparam int SB_OUT_GUARD_DIS = 8;
  localparam int SB_COAX_GUARD_DIS = 9;
  localparam int SB_GROUP_CTRL = 10;
  localparam int SB_ALWAYS_ONE = 11;
  localparam int SB_LIM_STATE = 12;
  localparam int SB_WIDE_STATE0 = 13;
  localparam int SB_RESET_LINE = 15;
  localparam int SB_OUT_GUARD_EVAL = 16;
  localparam int SB_COAX_GUARD_EVAL = 17;
  localparam int SB_GUARD_COMB = 18;
  localparam int SB_GROUP_STATE = 19;
  localparam int SB_EN_STATE0 = 20;
  localparam int SB_OUT_GUARD_RAW = 22;
  localparam int SB_COAX_GUARD_RAW = 23;
  // synchronised pin vector layout
  localparam int PIN_W = 11;
  localparam int PN_PURGE = 0;
  localparam int PN_LIM_CTRL = 1;
  localparam int PN_RGB0 = 2;
  localparam int PN_LIM_STATE = 5;
  localparam int PN_RESET = 6;
  localparam int PN_OUT_RAW = 7;
  localparam int PN_COAX_RAW = 8;
  localparam int PN_CAP0 = 9;
  // reset values
  localparam logic [1:0] RST_ENABLE = 2'h0;
  localparam logic [1:0] RST_WIDE = 2'h0;
endpackage : psu_cmd_pkg

// ### rtl/dual_psu_command_status_unit.sv
`timescale 1ns/1ps
module dual_psu_command_status_unit (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // received characters
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // transmitted characters
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // link purge pin and speed fallback
  input wire logic purge_req,
  output logic baud_default,
  // pins from the supply hardware
  input wire logic inrush_limiter_control,
  input wire logic [2:0] indicator_on,
  input wire logic inrush_limiter_state,
  input wire logic module_reset_low,
  input wire logic output_loop_guard_raw,
  input wire logic coax_loop_guard_raw,
  input wire logic [1:0] range_capable,
  // from the device controller
  input wire logic device_enabled,
  input wire logic error_present,
  input wire logic output_loop_enable,
  input wire logic coax_loop_enable,
  // setpoint write from the set-voltage path
  input wire logic setpoint_wr,
  input wire logic setpoint_sel,
  input wire logic [psu_cmd_pkg::VOLT_W-1:0] setpoint_data,
  // module drive and status view
  output logic positive_module_flag,
  output logic negative_module_flag,
  output logic [psu_cmd_pkg::ST_W-1:0] module_status_word
);
  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_LOAD, S_SEND} state_t;

  // all state of the block outside the setpoint store in one record
  typedef struct packed {
    // two-stage pin synchroniser, then the last purge level
    logic [psu_cmd_pkg::PIN_W-1:0] sync1;
    logic [psu_cmd_pkg::PIN_W-1:0] sync2;
    logic purge_last;
    state_t state;
    // command collection
    logic [psu_cmd_pkg::RX_DEPTH-1:0][7:0] rbuf;
    logic [2:0] rcnt;
    logic overflow;
    // reply buffer, its length and the character on offer
    logic [psu_cmd_pkg::TX_DEPTH-1:0][7:0] tbuf;
    logic [3:0] tlen;
    logic [3:0] tidx;
    // registered link outputs
    logic [7:0] tx_data;
    logic tx_valid;
    logic rx_ready;
    // flags written by set commands
    logic [1:0] enable;
    logic [1:0] wide;
    // module drive, speed fallback pulse, voltage select, status view
    logic [1:0] mod_drive;
    logic baud_default;
    logic vsel;
    logic [psu_cmd_pkg::ST_W-1:0] status;
  } regs_t;

  regs_t cur_r;
  regs_t cur_nxt;
  logic [psu_cmd_pkg::VOLT_W-1:0] volt_rd;
  logic [psu_cmd_pkg::PIN_W-1:0] pins;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // upper-case hex character of a nibble
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    if (nib < 4'ha) begin
      hex_char = 8'h30 + {4'h0, nib};
    end else begin
      hex_char = 8'h37 + {4'h0, nib};
    end
  endfunction : hex_char

  // boolean character of a flag
  function automatic logic [7:0] bool_char(input logic b);
    bool_char = b ? psu_cmd_pkg::CH_ONE : psu_cmd_pkg::CH_ZERO;
  endfunction : bool_char

  // character is '0' or '1'
  function automatic logic is_bool(input logic [7:0] c);
    is_bool = (c == psu_cmd_pkg::CH_ZERO) || (c == psu_cmd_pkg::CH_ONE);
  endfunction : is_bool

  ////////////////////////////////////////////////////////////////////////////
  // setpoint store

  setpoint_store u_store (
    .clock(clock),
    .resetn(resetn),
    .wr_en(setpoint_wr),
    .wr_sel(setpoint_sel),
    .wr_data(setpoint_data),
    .rd_sel(cur_r.vsel),
    .rd_data(volt_rd)
  );

  // pins gathered for synchronising
  assign pins = {range_capable, coax_loop_guard_raw, output_loop_guard_raw, module_reset_low,
                 inrush_limiter_state, indicator_on, inrush_limiter_control, purge_req};

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    // scratch values, each given a value before use
    logic [psu_cmd_pkg::ST_W-1:0] sw;
    logic out_eval;
    logic coax_eval;
    logic group_ctrl;
    logic group_on;
    logic [7:0] cmd;
    logic [7:0] arg1;
    logic [7:0] arg2;
    logic digit_ok;
    logic [1:0] cap;
    logic [23:0] vwide;
    sw = '0;
    out_eval = 1'b0;
    coax_eval = 1'b0;
    group_ctrl = 1'b0;
    group_on = 1'b0;
    cmd = cur_r.rbuf[0];
    arg1 = cur_r.rbuf[1];
    arg2 = cur_r.rbuf[2];
    digit_ok = is_bool(arg1);
    cap = cur_r.sync2[psu_cmd_pkg::PN_CAP0 +: 2];
    vwide = {4'h0, volt_rd};
    // everything holds unless a branch below says otherwise
    cur_nxt = cur_r;
    cur_nxt.sync1 = pins;
    cur_nxt.sync2 = cur_r.sync1;
    cur_nxt.purge_last = cur_r.sync2[psu_cmd_pkg::PN_PURGE];
    cur_nxt.baud_default = 1'b0;

    // loop guards: an enabled guard passes only when its loop is closed
    // a disabled guard always reads as passing
    out_eval = !output_loop_enable || cur_r.sync2[psu_cmd_pkg::PN_OUT_RAW];
    coax_eval = !coax_loop_enable || cur_r.sync2[psu_cmd_pkg::PN_COAX_RAW];
    group_ctrl = device_enabled && !error_present;
    group_on = group_ctrl && out_eval && coax_eval;

    // status word assembled from live state only
    // a status reply reads this copy, so it shows the word of the terminator cycle
    sw[psu_cmd_pkg::SB_LIM_CTRL] = cur_r.sync2[psu_cmd_pkg::PN_LIM_CTRL];
    sw[psu_cmd_pkg::SB_RED +: 3] = cur_r.sync2[psu_cmd_pkg::PN_RGB0 +: 3];
    sw[psu_cmd_pkg::SB_EN_CTRL0 +: 2] = cur_r.enable;
    sw[psu_cmd_pkg::SB_WIDE_CTRL0 +: 2] = cur_r.wide;
    sw[psu_cmd_pkg::SB_OUT_GUARD_DIS] = !output_loop_enable;
    sw[psu_cmd_pkg::SB_COAX_GUARD_DIS] = !coax_loop_enable;
    sw[psu_cmd_pkg::SB_GROUP_CTRL] = group_ctrl;
    sw[psu_cmd_pkg::SB_ALWAYS_ONE] = 1'b1;
    sw[psu_cmd_pkg::SB_LIM_STATE] = cur_r.sync2[psu_cmd_pkg::PN_LIM_STATE];
    sw[psu_cmd_pkg::SB_WIDE_STATE0 +: 2] = cur_r.wide & cap;
    sw[psu_cmd_pkg::SB_RESET_LINE] = cur_r.sync2[psu_cmd_pkg::PN_RESET];
    sw[psu_cmd_pkg::SB_OUT_GUARD_EVAL] = out_eval;
    sw[psu_cmd_pkg::SB_COAX_GUARD_EVAL] = coax_eval;
    sw[psu_cmd_pkg::SB_GUARD_COMB] = out_eval && coax_eval;
    sw[psu_cmd_pkg::SB_GROUP_STATE] = group_on;
    sw[psu_cmd_pkg::SB_EN_STATE0 +: 2] = {2{group_on}} & cur_r.enable;
    sw[psu_cmd_pkg::SB_OUT_GUARD_RAW] = cur_r.sync2[psu_cmd_pkg::PN_OUT_RAW];
    sw[psu_cmd_pkg::SB_COAX_GUARD_RAW] = cur_r.sync2[psu_cmd_pkg::PN_COAX_RAW];
    cur_nxt.status = sw;
    cur_nxt.mod_drive = sw[psu_cmd_pkg::SB_EN_STATE0 +: 2];

    unique case (cur_r.state)
      // collect characters up to the terminator
      S_IDLE: begin
        if (rx_valid) begin
          if (rx_data != psu_cmd_pkg::CH_TERM) begin
            // a command longer than the buffer is dropped whole at its terminator
            if (cur_r.rcnt < 3'(psu_cmd_pkg::RX_DEPTH)) begin
              cur_nxt.rbuf[cur_r.rcnt[1:0]] = rx_data;
              cur_nxt.rcnt = cur_r.rcnt + 3'h1;
            end else begin
              cur_nxt.overflow = 1'b1;
            end
          end else begin
            cur_nxt.rcnt = '0;
            cur_nxt.overflow = 1'b0;
            cur_nxt.tidx = '0;
            // every reply opens with the command letter
            cur_nxt.tbuf[0] = cmd;
            if (!cur_r.overflow && cur_r.rcnt == 3'h1) begin
              // queries with two boolean characters
              if (cmd == psu_cmd_pkg::CH_ENABLE) begin
                cur_nxt.tbuf[1] = bool_char(cur_r.enable[0]);
                cur_nxt.tbuf[2] = bool_char(cur_r.enable[1]);
                cur_nxt.tlen = psu_cmd_pkg::LEN_BOOL;
              end else if (cmd == psu_cmd_pkg::CH_RANGE_CAP) begin
                cur_nxt.tbuf[1] = bool_char(cap[0]);
                cur_nxt.tbuf[2] = bool_char(cap[1]);
                cur_nxt.tlen = psu_cmd_pkg::LEN_BOOL;
              end else if (cmd == psu_cmd_pkg::CH_WIDE) begin
                cur_nxt.tbuf[1] = bool_char(cur_r.wide[0]);
                cur_nxt.tbuf[2] = bool_char(cur_r.wide[1]);
                cur_nxt.tlen = psu_cmd_pkg::LEN_BOOL;
              end
            end else if (!cur_r.overflow && cur_r.rcnt == 3'h2 && digit_ok) begin
              cur_nxt.tbuf[1] = arg1;
              if (cmd == psu_cmd_pkg::CH_STATUS) begin
                for (int i = 0; i < psu_cmd_pkg::STATUS_DIGITS; i++) begin
                  cur_nxt.tbuf[2 + i] = hex_char(sw[4 * (5 - i) +: 4]);
                end
                cur_nxt.tlen = psu_cmd_pkg::LEN_STATUS;
              end else if (cmd == psu_cmd_pkg::CH_VOLT) begin
                cur_nxt.vsel = arg1[0];
                cur_nxt.state = S_FETCH;
              end
            end else if (!cur_r.overflow && cur_r.rcnt == 3'h3 && is_bool(arg1) &&
                         is_bool(arg2)) begin
              // set commands are echoed character for character
              if (cmd == psu_cmd_pkg::CH_ENABLE) begin
                cur_nxt.enable = {arg2[0], arg1[0]};
                cur_nxt.tbuf[1] = arg1;
                cur_nxt.tbuf[2] = arg2;
                cur_nxt.tlen = psu_cmd_pkg::LEN_BOOL;
              end else if (cmd == psu_cmd_pkg::CH_WIDE) begin
                // a module that cannot switch keeps its old range flag
                cur_nxt.wide[0] = cap[0] ? arg1[0] : cur_r.wide[0];
                cur_nxt.wide[1] = cap[1] ? arg2[0] : cur_r.wide[1];
                cur_nxt.tbuf[1] = arg1;
                cur_nxt.tbuf[2] = arg2;
                cur_nxt.tlen = psu_cmd_pkg::LEN_BOOL;
              end
            end
            // a reply was built when its length was loaded; otherwise nothing is sent
            if (cur_nxt.tlen != '0 && cur_nxt.state == S_IDLE) begin
              cur_nxt.tbuf[cur_nxt.tlen - 4'h1] = psu_cmd_pkg::CH_TERM;
              cur_nxt.tx_data = cmd;
              cur_nxt.tx_valid = 1'b1;
              cur_nxt.state = S_SEND;
            end
          end
        end
      end
      // store read address settles
      // one edge for the new address, one for the read register
      S_FETCH: begin
        cur_nxt.state = S_LOAD;
      end
      // setpoint is in the read register
      // five digits of the twenty-bit setpoint, terminator last
      S_LOAD: begin
        for (int i = 0; i < psu_cmd_pkg::VOLT_DIGITS; i++) begin
          cur_nxt.tbuf[2 + i] = hex_char(vwide[4 * (4 - i) +: 4]);
        end
        cur_nxt.tbuf[7] = psu_cmd_pkg::CH_TERM;
        cur_nxt.tlen = psu_cmd_pkg::LEN_VOLT;
        cur_nxt.tx_data = cur_r.tbuf[0];
        cur_nxt.tx_valid = 1'b1;
        cur_nxt.state = S_SEND;
      end
      // hand out characters one per accepted transfer
      S_SEND: begin
        if (tx_ready) begin
          // the terminator is the last character handed over
          if (cur_r.tidx + 4'h1 < cur_r.tlen) begin
            cur_nxt.tidx = cur_r.tidx + 4'h1;
            cur_nxt.tx_data = cur_r.tbuf[cur_r.tidx + 4'h1];
          end else begin
            cur_nxt.tx_valid = 1'b0;
            cur_nxt.tlen = '0;
            cur_nxt.state = S_IDLE;
          end
        end
      end
    endcase

    // purge: drop partial command and reply, fall back to default speed
    // purge wins over the state and reply decoded in the same cycle; enable and range writes still land
    if (cur_r.sync2[psu_cmd_pkg::PN_PURGE]) begin
      cur_nxt.rcnt = '0;
      cur_nxt.overflow = 1'b0;
      cur_nxt.tlen = '0;
      cur_nxt.tx_valid = 1'b0;
      cur_nxt.state = S_IDLE;
      cur_nxt.baud_default = !cur_r.purge_last;
    end
    // ready only while collecting, so nothing arrives during a reply
    cur_nxt.rx_ready = (cur_nxt.state == S_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // reset branch loads constants only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cur_r <= '0;
      cur_r.state <= S_IDLE;
      cur_r.enable <= psu_cmd_pkg::RST_ENABLE;
      cur_r.wide <= psu_cmd_pkg::RST_WIDE;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // outputs straight from the state register
  assign rx_ready = cur_r.rx_ready;
  assign tx_data = cur_r.tx_data;
  assign tx_valid = cur_r.tx_valid;
  assign baud_default = cur_r.baud_default;
  assign positive_module_flag = cur_r.mod_drive[0];
  assign negative_module_flag = cur_r.mod_drive[1];
  assign module_status_word = cur_r.status;
endmodule : dual_psu_command_status_unit

// ### rtl/setpoint_store.sv
`timescale 1ns/1ps
// two-word setpoint memory, registered read
module setpoint_store (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // write side
  input wire logic wr_en,
  input wire logic wr_sel,
  input wire logic [psu_cmd_pkg::VOLT_W-1:0] wr_data,
  // read side
  input wire logic rd_sel,
  output logic [psu_cmd_pkg::VOLT_W-1:0] rd_data
);
  logic [1:0][psu_cmd_pkg::VOLT_W-1:0] mem_r;

  // storage and read register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mem_r <= '0;
      rd_data <= '0;
    end else begin
      if (wr_en) begin
        mem_r[wr_sel] <= wr_data;
      end
      rd_data <= mem_r[rd_sel];
    end
  end
endmodule : setpoint_store

// ### sim/link_host.sv
`timescale 1ns/1ps
// host end of the character link: sends commands and collects replies
module link_host (
  // clock
  input wire logic clock,
  // characters to the device
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // characters from the device
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  int stall = 0;
  int timeouts = 0;
  // idle link at time zero
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  ////////////////////////////////////////////////
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  // each character held until taken; released data shows the inverse
  task automatic send(input string s, input bit term);
    int n;
    for (int i = 0; i < s.len() + term; i++) begin
      rx_data = (i < s.len()) ? s[i] : psu_cmd_pkg::CH_TERM;
      rx_valid = 1'b1;
      n = 0;
      while (!rx_ready && n < 50) begin
        tick();
        n++;
      end
      timeouts = (n == 50) ? timeouts + 1 : timeouts;
      tick();
    end
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask : send
  // collect one reply, the terminator shown as a dollar sign
  task automatic recv(output string s);
    int n;
    s = "";
    n = 0;
    while (n < 60) begin
      if (tx_valid) begin
        if (stall > 0) begin
          tx_ready = 1'b0;
          repeat (stall) tick();
        end
        s = (tx_data == psu_cmd_pkg::CH_TERM) ? {s, "$"} : $sformatf("%s%c", s, tx_data);
        n = (tx_data == psu_cmd_pkg::CH_TERM) ? 60 : n;
        tx_ready = 1'b1;
        tick();
      end else begin
        tx_ready = 1'b0;
        tick();
        n++;
      end
    end
    tx_ready = 1'b0;
  endtask : recv
endmodule : link_host

// ### sim/status_properties.sv
`timescale 1ns/1ps
// port-level properties of the command and status unit
module status_properties (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // character link
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  // purge
  input wire logic purge_req,
  input wire logic baud_default,
  // controller levels
  input wire logic device_enabled,
  input wire logic error_present,
  input wire logic output_loop_enable,
  input wire logic coax_loop_enable,
  // status view
  input wire logic positive_module_flag,
  input wire logic negative_module_flag,
  input wire logic [psu_cmd_pkg::ST_W-1:0] module_status_word
);
  logic [23:0] sw;
  // short alias for the status word
  assign sw = module_status_word;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////
  // a terminator taken, then the first reply character appearing
  sequence s_term_taken;
    rx_valid && rx_ready && rx_data == psu_cmd_pkg::CH_TERM;
  endsequence
  sequence s_reply_open;
    !tx_valid ##1 tx_valid;
  endsequence
  a_spare_one: assert property ($past(resetn) |-> sw[11])
    else $error("spare status bit not one");
  a_group_ctrl: assert property ($past(resetn) |->
    sw[10] == $past(device_enabled && !error_present)) else $error("group enable control wrong");
  a_guard_dis: assert property ($past(resetn) |->
    sw[9:8] == ~$past({coax_loop_enable, output_loop_enable}))
    else $error("guard disable bits wrong");
  a_guard_eval: assert property (sw[16] == (sw[8] | sw[22]) && sw[17] == (sw[9] | sw[23])
    && sw[18] == (sw[16] & sw[17])) else $error("evaluated guard bits wrong");
  a_group_state: assert property (sw[19] == (sw[10] & sw[18])
    && sw[21:20] == ({2{sw[19]}} & sw[5:4])) else $error("enabled state bits wrong");
  a_drive_mirror: assert property (
    {negative_module_flag, positive_module_flag} == sw[21:20])
    else $error("module drive differs from status");
  a_purge_pulse: assert property ($rose(purge_req) |-> ##[1:3] baud_default)
    else $error("no speed fallback after purge");
  a_pulse_single: assert property (baud_default |=> !baud_default)
    else $error("speed fallback longer than one cycle");
  a_reply_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply character dropped before taken");
  a_reply_letter: assert property (s_term_taken ##[0:2] s_reply_open |-> tx_data inside
    {psu_cmd_pkg::CH_STATUS, psu_cmd_pkg::CH_ENABLE, psu_cmd_pkg::CH_RANGE_CAP,
     psu_cmd_pkg::CH_WIDE, psu_cmd_pkg::CH_VOLT}) else $error("reply does not open with letter");
endmodule : status_properties

bind dual_psu_command_status_unit status_properties i_props (
  .clock(clock), .resetn(resetn), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .purge_req(purge_req),
  .baud_default(baud_default), .device_enabled(device_enabled), .error_present(error_present),
  .output_loop_enable(output_loop_enable), .coax_loop_enable(coax_loop_enable),
  .positive_module_flag(positive_module_flag), .negative_module_flag(negative_module_flag),
  .module_status_word(module_status_word));

// ### sim/tb.sv
`timescale 1ns/1ps
// command and status bench
module tb;
  logic clock, resetn, rx_valid, rx_ready, tx_valid, tx_ready, purge_req, baud_default;
  logic lim_ctrl, lim_state, reset_low, out_raw, coax_raw, dev_en, err, out_en, coax_en;
  logic sp_wr, sp_sel, pos_flag, neg_flag;
  logic [7:0] rx_data, tx_data;
  logic [2:0] ind;
  logic [1:0] cap, en_x, wide_x;
  logic [19:0] sp_data;
  logic [23:0] status, w;
  logic [11:0] pins [4] = '{12'hd6a, 12'h29b, 12'hfff, 12'h048};
  string bad [6] = '{"x", "s2", "e1", "e1x", "s0FF", "e10x1"};
  string c;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  dual_psu_command_status_unit i_dut (.clock(clock), .resetn(resetn), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .purge_req(purge_req), .baud_default(baud_default),
    .inrush_limiter_control(lim_ctrl), .indicator_on(ind), .inrush_limiter_state(lim_state),
    .module_reset_low(reset_low), .output_loop_guard_raw(out_raw),
    .coax_loop_guard_raw(coax_raw), .range_capable(cap), .device_enabled(dev_en),
    .error_present(err), .output_loop_enable(out_en), .coax_loop_enable(coax_en),
    .setpoint_wr(sp_wr), .setpoint_sel(sp_sel), .setpoint_data(sp_data),
    .positive_module_flag(pos_flag), .negative_module_flag(neg_flag),
    .module_status_word(status));
  link_host i_host (.clock(clock), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  ////////////////////////////////////////////////
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : step
  task automatic check_str(input string what, input string exp, input string seen);
    total_checks++;
    if (seen != exp) begin
      n_errors++;
      $display("mismatch %s expected %s seen %s", what, exp, seen);
    end
  endtask : check_str
  task automatic check_bit(input string what, input logic exp, input logic seen);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", what, exp, seen);
    end
  endtask : check_bit
  task automatic query(input string cmd, input string exp);
    string got;
    i_host.send(cmd, 1'b1);
    i_host.recv(got);
    check_str(cmd, exp, got);
  endtask : query
  task automatic put_setpoint(input logic sel, input logic [19:0] v);
    sp_sel = sel;
    sp_data = v;
    sp_wr = 1'b1;
    step(1);
    sp_wr = 1'b0;
    step(1);
  endtask : put_setpoint
  // upper-case hex, most significant digit first
  function automatic string hexs(input logic [23:0] v, input int k);
    string s, hd;
    s = "";
    hd = "0123456789ABCDEF";
    for (int i = k - 1; i >= 0; i--) s = {s, hd.substr(v[4*i +: 4], v[4*i +: 4])};
    return s;
  endfunction : hexs
  // expected status word from the levels driven here
  function automatic logic [23:0] word();
    logic e0, e1, g;
    e0 = !out_en | out_raw;
    e1 = !coax_en | coax_raw;
    g = dev_en & !err & e0 & e1;
    return {coax_raw, out_raw, g & en_x[1], g & en_x[0], g, e0 & e1, e1, e0, reset_low,
      wide_x & cap, lim_state, 1'b1, dev_en & !err, !coax_en, !out_en,
      wide_x, en_x, ind, lim_ctrl};
  endfunction : word
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    {resetn, purge_req, sp_wr, sp_sel, sp_data, en_x, wide_x, cap} = '0;
    {lim_ctrl, ind, lim_state, reset_low, out_raw, coax_raw,
     dev_en, err, out_en, coax_en} = pins[0];
    cap = 2'h1;
    step(8);
    resetn = 1'b1;
    step(2);
    query("e", "e00$");
    query("p", "p00$");
    query("e10", "e10$");
    en_x = 2'h1;
    query("e", "e10$");
    query("r", "r10$");
    i_host.stall = 2;
    query("p11", "p11$");
    wide_x = 2'h1;
    query("p", "p10$");
    for (int k = 0; k < 4; k++) begin
      {lim_ctrl, ind, lim_state, reset_low, out_raw, coax_raw,
       dev_en, err, out_en, coax_en} = pins[k];
      step(4);
      w = word();
      c = $sformatf("s%0d", k % 2);
      query(c, {c, hexs(w, 6), "$"});
      check_str("status port", hexs(w, 6), hexs(status, 6));
      check_bit("positive drive", w[20], pos_flag);
      check_bit("negative drive", w[21], neg_flag);
    end
    i_host.stall = 0;
    // second module alone enabled, group still on
    query("e01", "e01$");
    en_x = 2'h2;
    w = word();
    check_bit("negative drive alone", w[21], neg_flag);
    check_bit("positive drive off", w[20], pos_flag);
    put_setpoint(1'b1, 20'habc12);
    put_setpoint(1'b0, 20'h00f3d);
    query("O1", "O1ABC12$");
    query("O0", "O000F3D$");
    foreach (bad[i]) query(bad[i], "");
    query("e", "e01$");
    i_host.send("e1", 1'b0);
    purge_req = 1'b1;
    n = 0;
    while (!baud_default && n < 10) begin
      step(1);
      n++;
    end
    check_bit("baud_default", 1'b1, baud_default);
    purge_req = 1'b0;
    step(6);
    query("r", "r10$");
    check_bit("link stall", 1'b0, i_host.timeouts != 0);
    conclude();
  end
endmodule : tb
